// file: src/mfc_pkg.sv
// constants and types for the modulator front end control
package mfc_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned MCLK_STOP_NS  = 100000;
  localparam int unsigned MCLK_STOP_CYC = MCLK_STOP_NS / CLK_PERIOD_NS;
  localparam int unsigned BBM_GAP_NS    = 200;
  localparam int unsigned BBM_GAP_CYC   = (BBM_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RUN_LEN       = 16;

  // ----------------------------------------
  // control bus codes
  // ----------------------------------------
  localparam logic [1:0] SRC_GROUND   = 2'h0;
  localparam logic [1:0] SRC_TEST     = 2'h1;
  localparam logic [1:0] SRC_SIGNAL   = 2'h2;
  localparam logic [2:0] GAIN_0DB     = 3'h0;
  localparam logic [2:0] GAIN_MAX     = 3'h4;
  localparam logic [2:0] AMP_PD_CODE  = 3'h5;
  localparam logic [1:0] CHIP_PD_CODE = 2'h3;
  localparam logic [4:0] CODE_REF     = 5'h18;
  localparam logic [4:0] CODE_SENSE1  = 5'h19;
  localparam logic [4:0] CODE_SENSE2  = 5'h1a;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [3:0]  REG_STATUS  = 4'h0;
  localparam logic [3:0]  REG_MASK    = 4'h4;
  localparam logic [3:0]  REG_STATE   = 4'h8;
  localparam logic [3:0]  REG_CONFIG  = 4'hc;
  localparam logic [3:0]  EVT_OVR     = 4'h1;
  localparam logic [3:0]  EVT_CHIPPD  = 4'h2;
  localparam logic [3:0]  EVT_STOP    = 4'h4;
  localparam logic [3:0]  EVT_RSVD    = 4'h8;
  localparam logic [3:0]  MASK_RESET  = 4'h0;
  localparam logic [1:0]  CFG_RESET   = 2'h3;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    MFC_GROUND, MFC_TEST, MFC_SIGNAL, MFC_REF, MFC_SENSE1, MFC_SENSE2
  } mfc_src_type;

  typedef struct packed {
    logic ref_p;
    logic ref_n;
    logic gnd_p;
    logic gnd_n;
    logic test_p;
    logic test_n;
    logic sig_p;
    logic sig_n;
  } mfc_switch_type;

  typedef struct packed {
    mfc_src_type src;
    logic [2:0]  gain;
    logic        amp_pd;
    logic        chip_pd;
    logic        reserved;
  } mfc_decode_type;

endpackage

// file: src/mfc_frontend_control.sv
// control bus decode, switch sequencing and overrange detect
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - low three bus bits pick gain 0, 12, 24, 36 or 48 dB.
// - high bits 00 with gain code select grounded input through resistor.
// - high bits 01 with gain code route test pair to amplifier.
// - high bits 10 with gain code route signal pair to amplifier.
// - code 11000 selects the reference source at 0 dB.
// - code 11001 closes signal and test pairs at 0 dB.
// - code 11010 closes positive signal and both test switches.
// - plain sources close only their own switch pair.
// - low field 101 powers down amplifier and multiplexer only.
// - bits two and one both high power the whole chip down.
// - stopped modulator clock powers the chip down; decode needs clock.
// - any power-down selects the grounded input.
// - switches break before make on every selection change.
// - sixteen identical modulator bits in a row are an overrange.
// - overrange resets the modulator loop and raises the flag.
// - flag falls one and a half modulator clocks after rising.
module mfc_frontend_control
  import mfc_pkg::*;
#(
  parameter int unsigned STOP_CYCLES = MCLK_STOP_CYC,
  parameter int unsigned GAP_CYCLES  = BBM_GAP_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  front_end_control_bus,
  input  wire logic        modulator_clock,
  input  wire logic        modulator_bit,
  output mfc_switch_type   switch_close,
  output logic [2:0]       amplifier_gain,
  output logic             amplifier_power_down,
  output logic             chip_power_down,
  output logic             modulator_reset,
  output logic             overrange_flag,
  output logic             irq,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [31:0] s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);

  initial begin
    if (STOP_CYCLES < 2 || STOP_CYCLES > 65535) begin
      $error("STOP_CYCLES out of range");
    end
    if (GAP_CYCLES < 1 || GAP_CYCLES > 255) begin
      $error("GAP_CYCLES out of range");
    end
  end

  // ----------------------------------------
  // decode functions
  // ----------------------------------------

  // chip power-down first, then amplifier power-down, then the table
  function automatic mfc_decode_type decode_bus(input logic [4:0] code);
    mfc_decode_type d;
    d = '{src: MFC_GROUND, gain: GAIN_0DB, amp_pd: 1'b0,
          chip_pd: 1'b0, reserved: 1'b0};
    if (code[2:1] == CHIP_PD_CODE) begin
      d.chip_pd = 1'b1;
    end else if (code[2:0] == AMP_PD_CODE) begin
      d.amp_pd = 1'b1;
    end else if (code == CODE_REF) begin
      d.src = MFC_REF;
    end else if (code == CODE_SENSE1) begin
      d.src = MFC_SENSE1;
    end else if (code == CODE_SENSE2) begin
      d.src = MFC_SENSE2;
    end else if (code[2:0] <= GAIN_MAX && code[4:3] != 2'h3) begin
      d.gain = code[2:0];
      if (code[4:3] == SRC_GROUND) begin
        d.src = MFC_GROUND;
      end else if (code[4:3] == SRC_TEST) begin
        d.src = MFC_TEST;
      end else begin
        d.src = MFC_SIGNAL;
      end
    end else begin
      d.reserved = 1'b1;
    end
    return d;
  endfunction

  // switch pattern per source; all others stay open
  function automatic mfc_switch_type switch_map(input mfc_src_type s);
    mfc_switch_type w;
    w = '0;
    case (s)
      MFC_GROUND: begin
        w.gnd_p = 1'b1;
        w.gnd_n = 1'b1;
      end
      MFC_REF: begin
        w.ref_p = 1'b1;
        w.ref_n = 1'b1;
      end
      MFC_SIGNAL: begin
        w.sig_p = 1'b1;
        w.sig_n = 1'b1;
      end
      MFC_TEST: begin
        w.test_p = 1'b1;
        w.test_n = 1'b1;
      end
      MFC_SENSE1: begin
        w.sig_p  = 1'b1;
        w.sig_n  = 1'b1;
        w.test_p = 1'b1;
        w.test_n = 1'b1;
      end
      MFC_SENSE2: begin
        w.sig_p  = 1'b1;
        w.test_p = 1'b1;
        w.test_n = 1'b1;
      end
      default: begin
        w = '0;
      end
    endcase
    return w;
  endfunction

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------

  // bus, bit and clock all arrive from outside this clock domain
  localparam int unsigned SW = 7;
  logic [SW-1:0] in_s1_reg;
  logic [SW-1:0] in_s2_reg;
  logic [SW-1:0] in_s3_reg;
  logic [SW-1:0] in_ok_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      in_s1_reg <= '0;
      in_s2_reg <= '0;
      in_s3_reg <= '0;
    end else begin
      in_s1_reg <= {front_end_control_bus, modulator_bit, modulator_clock};
      in_s2_reg <= in_s1_reg;
      in_s3_reg <= in_s2_reg;
    end
  end

  // a bit changes only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < SW; gi++) begin : g_agree
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          in_ok_reg[gi] <= 1'b0;
        end else if (in_s2_reg[gi] == in_s3_reg[gi]) begin
          in_ok_reg[gi] <= in_s3_reg[gi];
        end
      end
    end
  endgenerate

  wire logic [4:0] bus_code = in_ok_reg[6:2];
  wire logic       mod_bit  = in_ok_reg[1];
  wire logic       mclk_lvl = in_ok_reg[0];

  // ----------------------------------------
  // modulator clock watch
  // ----------------------------------------
  logic        mclk_prev_reg;
  logic [15:0] idle_cnt_reg;
  logic        mclk_stopped_reg;
  logic [1:0]  cfg_reg;

  wire logic mclk_rise  = mclk_lvl & ~mclk_prev_reg;
  wire logic mclk_fall  = ~mclk_lvl & mclk_prev_reg;
  wire logic mclk_edge  = mclk_rise | mclk_fall;
  wire logic watch_en   = cfg_reg[0];
  wire logic idle_limit = idle_cnt_reg == 16'(STOP_CYCLES - 1);

  // stopped after STOP_CYCLES without any edge; held stopped until next edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mclk_prev_reg    <= 1'b0;
      idle_cnt_reg     <= '0;
      mclk_stopped_reg <= 1'b1;
    end else begin
      mclk_prev_reg <= mclk_lvl;
      if (mclk_edge) begin
        idle_cnt_reg     <= '0;
        mclk_stopped_reg <= 1'b0;
      end else if (idle_limit) begin
        mclk_stopped_reg <= watch_en;
      end else begin
        idle_cnt_reg <= idle_cnt_reg + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // selection and power-down
  // ----------------------------------------

  // decode applies only while the modulator clock runs
  wire mfc_decode_type dec       = decode_bus(bus_code);
  wire logic           chip_down = dec.chip_pd | mclk_stopped_reg;
  wire logic           any_down  = chip_down | dec.amp_pd;
  wire mfc_src_type    src_sel   = any_down ? MFC_GROUND : dec.src;
  wire mfc_switch_type target    = switch_map(src_sel);

  logic [2:0] gain_reg;
  logic       amp_pd_reg;
  logic       chip_pd_reg;
  logic       rsvd_prev_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gain_reg      <= GAIN_0DB;
      amp_pd_reg    <= 1'b0;
      chip_pd_reg   <= 1'b1;
      rsvd_prev_reg <= 1'b0;
    end else begin
      gain_reg      <= any_down ? GAIN_0DB : dec.gain;
      amp_pd_reg    <= dec.amp_pd & ~chip_down;
      chip_pd_reg   <= chip_down;
      rsvd_prev_reg <= dec.reserved & ~any_down;
    end
  end

  // ----------------------------------------
  // break-before-make sequencer
  // ----------------------------------------
  typedef enum logic {SEQ_HOLD, SEQ_BREAK} mfc_seq_type;
  mfc_seq_type    seq_reg;
  mfc_switch_type sw_reg;
  logic [7:0]     gap_reg;

  // open everything, wait the gap, then close the newest target
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seq_reg <= SEQ_HOLD;
      sw_reg  <= '0;
      gap_reg <= '0;
    end else begin
      case (seq_reg)
        SEQ_HOLD: begin
          if (target != sw_reg) begin
            sw_reg  <= '0;
            gap_reg <= 8'(GAP_CYCLES - 1);
            seq_reg <= SEQ_BREAK;
          end
        end
        SEQ_BREAK: begin
          if (gap_reg == 8'h00) begin
            sw_reg  <= target;
            seq_reg <= SEQ_HOLD;
          end else begin
            gap_reg <= gap_reg - 8'h01;
          end
        end
        default: begin
          seq_reg <= SEQ_HOLD;
        end
      endcase
    end
  end

  // ----------------------------------------
  // overrange detector
  // ----------------------------------------
  logic [4:0] run_reg;
  logic       last_bit_reg;
  logic       ovr_reg;
  logic       ovr_half_reg;

  // the counter runs only on modulator clock rises
  wire logic det_en   = cfg_reg[1] & ~chip_pd_reg;
  wire logic same_bit = mod_bit == last_bit_reg;
  wire logic run_hit  = mclk_rise & det_en & same_bit &
                        run_reg == 5'(RUN_LEN - 1);

  always_ff @(posedge clk) begin
    if (!rst_n || !det_en) begin
      run_reg      <= '0;
      last_bit_reg <= 1'b0;
    end else if (run_hit) begin
      run_reg <= '0;
    end else if (mclk_rise) begin
      last_bit_reg <= mod_bit;
      run_reg      <= (same_bit && run_reg != 5'h00) ? run_reg + 5'h01 : 5'h01;
    end
  end

  // flag rises at a clock rise, falls at the fall after the next rise
  always_ff @(posedge clk) begin
    if (!rst_n || mclk_stopped_reg) begin
      ovr_reg      <= 1'b0;
      ovr_half_reg <= 1'b0;
    end else if (run_hit) begin
      ovr_reg      <= 1'b1;
      ovr_half_reg <= 1'b0;
    end else if (ovr_reg && mclk_rise) begin
      ovr_half_reg <= 1'b1;
    end else if (ovr_half_reg && mclk_fall) begin
      ovr_reg      <= 1'b0;
      ovr_half_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // status, mask and interrupt
  // ----------------------------------------
  logic [3:0] status_reg;
  logic [3:0] mask_reg;
  logic       irq_reg;
  logic       stop_prev_reg;
  logic       chpd_prev_reg;
  logic       rsvd_seen_reg;
  logic       status_clr;

  wire logic [3:0] events = {rsvd_prev_reg & ~rsvd_seen_reg,
                             mclk_stopped_reg & ~stop_prev_reg,
                             chip_pd_reg & ~chpd_prev_reg,
                             run_hit};
  // a set in the clearing cycle wins
  wire logic [3:0] status_next = (status_clr ? 4'h0 : status_reg) | events;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_reg    <= '0;
      irq_reg       <= 1'b0;
      stop_prev_reg <= 1'b1;
      chpd_prev_reg <= 1'b1;
      rsvd_seen_reg <= 1'b0;
    end else begin
      status_reg    <= status_next;
      irq_reg       <= |(status_next & mask_reg);
      stop_prev_reg <= mclk_stopped_reg;
      chpd_prev_reg <= chip_pd_reg;
      rsvd_seen_reg <= rsvd_prev_reg;
    end
  end

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  logic        awready_reg;
  logic        wready_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic [3:0]  waddr_reg;
  logic        waddr_ok_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;

  wire logic aw_take  = s_axi_awvalid & awready_reg;
  wire logic w_take   = s_axi_wvalid & wready_reg;
  wire logic wr_do    = ~awready_reg & ~wready_reg & ~bvalid_reg;
  wire logic wr_mask  = wr_do && waddr_ok_reg && waddr_reg == REG_MASK;
  wire logic wr_cfg   = wr_do && waddr_ok_reg && waddr_reg == REG_CONFIG;
  wire logic wr_known = waddr_ok_reg && (waddr_reg == REG_MASK ||
                        waddr_reg == REG_CONFIG || waddr_reg == REG_STATUS ||
                        waddr_reg == REG_STATE);

  // address and data taken in either order; answer after both
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awready_reg  <= 1'b1;
      wready_reg   <= 1'b1;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= RESP_OKAY;
      waddr_reg    <= '0;
      waddr_ok_reg <= 1'b0;
      wdata_reg    <= '0;
      wstrb_reg    <= '0;
    end else begin
      if (aw_take) begin
        awready_reg  <= 1'b0;
        waddr_reg    <= s_axi_awaddr[3:0];
        waddr_ok_reg <= s_axi_awaddr[31:4] == 28'h0000000;
      end
      if (w_take) begin
        wready_reg <= 1'b0;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_do) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // software writes steer the mask and the detector configuration
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_reg <= MASK_RESET;
      cfg_reg  <= CFG_RESET;
    end else begin
      if (wr_mask && wstrb_reg[0]) begin
        mask_reg <= wdata_reg[3:0];
      end
      if (wr_cfg && wstrb_reg[0]) begin
        cfg_reg <= wdata_reg[1:0];
      end
    end
  end

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  logic        arready_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  wire logic       ar_take = s_axi_arvalid & arready_reg;
  wire logic       ar_hi   = s_axi_araddr[31:4] == 28'h0000000;
  wire logic [3:0] ar_low  = s_axi_araddr[3:0];
  wire logic [31:0] state_word = {9'h000, 3'(src_sel), sw_reg,
                                  ovr_reg, mclk_stopped_reg, chip_pd_reg,
                                  amp_pd_reg, gain_reg, bus_code};
  logic [31:0] rd_word;
  logic        rd_known;

  // unmapped addresses read zero with a slave error
  always_comb begin
    rd_word  = 32'h00000000;
    rd_known = ar_hi;
    if (ar_hi && ar_low == REG_STATUS) begin
      rd_word = {28'h0000000, status_reg};
    end else if (ar_hi && ar_low == REG_MASK) begin
      rd_word = {28'h0000000, mask_reg};
    end else if (ar_hi && ar_low == REG_STATE) begin
      rd_word = state_word;
    end else if (ar_hi && ar_low == REG_CONFIG) begin
      rd_word = {30'h0, cfg_reg};
    end else begin
      rd_known = 1'b0;
    end
  end

  assign status_clr = ar_take && ar_hi && ar_low == REG_STATUS;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= RESP_OKAY;
    end else if (ar_take) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_word;
      rresp_reg   <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign switch_close         = sw_reg;
  assign amplifier_gain       = gain_reg;
  assign amplifier_power_down = amp_pd_reg;
  assign chip_power_down      = chip_pd_reg;
  assign modulator_reset      = ovr_reg;
  assign overrange_flag       = ovr_reg;
  assign irq                  = irq_reg;
  assign s_axi_awready        = awready_reg;
  assign s_axi_wready         = wready_reg;
  assign s_axi_bvalid         = bvalid_reg;
  assign s_axi_bresp          = bresp_reg;
  assign s_axi_arready        = arready_reg;
  assign s_axi_rvalid         = rvalid_reg;
  assign s_axi_rdata          = rdata_reg;
  assign s_axi_rresp          = rresp_reg;

endmodule

`default_nettype wire

// file: sim/mfc_frontend_control_props.sv
// checker on the front end control ports
`timescale 1ns/1ns
`default_nettype none
module mfc_frontend_control_props
  import mfc_pkg::*;
(
  input wire logic           clk,
  input wire logic           rst_n,
  input wire logic [4:0]     front_end_control_bus,
  input wire mfc_switch_type switch_close,
  input wire logic [2:0]     amplifier_gain,
  input wire logic           amplifier_power_down,
  input wire logic           chip_power_down,
  input wire logic           modulator_reset,
  input wire logic           overrange_flag,
  input wire logic           s_axi_rvalid,
  input wire logic           s_axi_rready
);
  // ------
  // properties
  // ------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // only documented switch patterns may show
  a_legal_pattern: assert property (switch_close inside {8'h00, 8'h30, 8'hc0, 8'h03, 8'h0c, 8'h0f, 8'h0e})
    else $error("switch pattern not in decode set");
  a_gain_range: assert property (amplifier_gain <= 3'h4)
    else $error("gain code above 48 dB");
  // a new pattern only ever follows an all-open cycle
  a_break_first: assert property ((switch_close != $past(switch_close)) && ($past(switch_close) != 8'h00)
    |-> switch_close == 8'h00)
    else $error("switches made before break");
  a_pd_ground: assert property (chip_power_down |-> switch_close inside {8'h00, 8'h30} && amplifier_gain == 3'h0)
    else $error("chip power-down not on ground");
  a_amp_down: assert property (amplifier_power_down |-> switch_close inside {8'h00, 8'h30})
    else $error("amp power-down not on ground");
  a_ref_gain: assert property (switch_close == 8'hc0 |-> amplifier_gain == 3'h0)
    else $error("reference source not at 0 dB");
  // sync takes up to four clocks, so eight steady cycles is ample
  a_bus_chip_pd: assert property ((front_end_control_bus[2:1] == 2'h3) [*8] |-> chip_power_down)
    else $error("bits two and one high without power-down");
  a_flag_reset: assert property (overrange_flag == modulator_reset)
    else $error("loop reset and flag differ");
  a_flag_short: assert property ($rose(overrange_flag) |-> ##[1:20] !overrange_flag)
    else $error("overrange flag stays high");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped before taken");

  c_overrange: cover property ($rose(overrange_flag));
  c_wake: cover property ($fell(chip_power_down));
  c_sense2: cover property (switch_close == 8'h0e);
endmodule
`default_nettype wire

// file: sim/mfc_filter_model.sv
// behavioural companion filter: control bus, modulator clock and bitstream
`timescale 1ns/1ns
`default_nettype none
module mfc_filter_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [4:0] gain_select_pins,
  input  wire logic       cfg_load,
  input  wire logic [4:0] cfg_code,
  input  wire logic       clock_run,
  input  wire logic       bit_hold,
  input  wire logic       bit_level,
  output logic [4:0]      front_end_control_bus,
  output logic            modulator_clock,
  output logic            modulator_bit
);
  // ------
  // model
  // ------
  logic [1:0] div_reg;

  // config bits mirror the pins in reset, later loaded by writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      front_end_control_bus <= gain_select_pins;
    end else if (cfg_load) begin
      front_end_control_bus <= cfg_code;
    end
  end

  // clock at clk/8, held low when stopped; bit moves on the fall
  always_ff @(posedge clk) begin
    if (!rst_n || !clock_run) begin
      div_reg <= 2'h0;
      modulator_clock <= 1'b0;
      modulator_bit <= 1'b0;
    end else begin
      div_reg <= div_reg + 2'h1;
      if (div_reg == 2'h3) begin
        modulator_clock <= ~modulator_clock;
        if (modulator_clock) begin
          modulator_bit <= bit_hold ? bit_level : ~modulator_bit;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/mfc_frontend_control_bench.sv
// self-checking bench for the front end control
`timescale 1ns/1ns
`default_nettype none
module mfc_frontend_control_bench;
  // ------
  // stimulus and checks
  // ------
  localparam int MDIV = 8;
  logic clk = 1'b0, rst_n = 1'b0, cfg_load = 1'b0, clock_run = 1'b1, bit_hold = 1'b0, bit_level = 1'b0;
  logic [4:0] pins = 5'h11, cfg_code = 5'h00, front_end_control_bus;
  logic modulator_clock, modulator_bit, amplifier_power_down, chip_power_down, modulator_reset;
  logic overrange_flag, irq, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  mfc_pkg::mfc_switch_type switch_close;
  logic [2:0]  amplifier_gain;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd, s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  int fails = 0, n_compared = 0, n;
  logic [4:0]  codes [12] = '{5'h00, 5'h04, 5'h0b, 5'h11, 5'h18, 5'h19, 5'h1a, 5'h1d, 5'h0e, 5'h17, 5'h1c, 5'h12};
  // {switches, gain, amp down, chip down}
  logic [12:0] expv [12] = '{13'h0600, 13'h0610, 13'h018c, 13'h0064, 13'h1800, 13'h01e0, 13'h01c0,
                             13'h0602, 13'h0601, 13'h0601, 13'h0600, 13'h0068};

  always #20 clk = ~clk;

  mfc_filter_model u_far (.clk, .rst_n, .gain_select_pins(pins), .cfg_load, .cfg_code, .clock_run,
    .bit_hold, .bit_level, .front_end_control_bus, .modulator_clock, .modulator_bit);

  mfc_frontend_control #(.STOP_CYCLES(50), .GAP_CYCLES(2)) DUT (.clk, .rst_n, .front_end_control_bus,
    .modulator_clock, .modulator_bit, .switch_close, .amplifier_gain, .amplifier_power_down,
    .chip_power_down, .modulator_reset, .overrange_flag, .irq, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // address and data offered together, each released once taken
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    int k;
    aw = 1'b1;
    w = 1'b1;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while ((aw || w) && k < 50) begin
      @(posedge clk);
      k++;
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k >= 50) fails++;
  endtask

  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (k < 50) begin
      @(posedge clk);
      k++;
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (k >= 50) fails++;
  endtask

  task automatic set_code(input logic [4:0] c);
    cfg_code <= c;
    cfg_load <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b0;
    repeat (16) @(posedge clk);
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (40) @(posedge clk);
    check(switch_close, 8'h03);
    check(amplifier_gain, 3'h1);
    axi_read(32'hc, rd, rs);
    check(rd, 32'h3);
    axi_read(32'h4, rd, rs);
    check(rd, 32'h0);
    axi_read(32'h10, rd, rs);
    check(rs, 2'h2);
    axi_write(32'h20, 32'h1, rs);
    check(rs, 2'h2);
    $display("test reset and registers done");
    // every listed code, power-down and a reserved one
    for (int i = 0; i < 12; i++) begin
      set_code(codes[i]);
      check({switch_close, amplifier_gain, amplifier_power_down, chip_power_down}, expv[i]);
    end
    $display("test decode done");
    axi_read(32'h0, rd, rs);
    set_code(5'h1c);
    check(irq, 1'b0);
    axi_write(32'h4, 32'h8, rs);
    repeat (2) @(posedge clk);
    check(irq, 1'b1);
    axi_read(32'h0, rd, rs);
    check(rd & 32'h8, 32'h8);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    $display("test interrupt done");
    set_code(5'h12);
    // runs of zeros, then of ones
    for (int v = 0; v < 2; v++) begin
      bit_level <= v[0];
      bit_hold <= 1'b1;
      repeat (13 * MDIV) @(posedge clk);
      check(overrange_flag, 1'b0);
      n = 0;
      while (overrange_flag !== 1'b1 && n < 100) begin
        @(posedge clk);
        n++;
      end
      check(modulator_reset, 1'b1);
      n = 0;
      while (overrange_flag === 1'b1 && n < 50) begin
        @(posedge clk);
        n++;
      end
      check(n, MDIV * 3 / 2);
      bit_hold <= 1'b0;
      repeat (40) @(posedge clk);
    end
    axi_write(32'hc, 32'h1, rs);
    axi_read(32'h0, rd, rs);
    bit_hold <= 1'b1;
    repeat (40 * MDIV) @(posedge clk);
    axi_read(32'h0, rd, rs);
    check(rd & 32'h1, 32'h0);
    bit_hold <= 1'b0;
    $display("test overrange done");
    clock_run <= 1'b0;
    repeat (70) @(posedge clk);
    check(chip_power_down, 1'b1);
    check(switch_close, 8'h30);
    clock_run <= 1'b1;
    repeat (40) @(posedge clk);
    check(chip_power_down, 1'b0);
    $display("test clock stop done");
    wrap_up;
  end

  // the tests need under 2000 cycles
  initial begin
    #(40 * 5000);
    fails++;
    wrap_up;
  end
endmodule

bind mfc_frontend_control mfc_frontend_control_props u_props (.clk, .rst_n, .front_end_control_bus,
  .switch_close, .amplifier_gain, .amplifier_power_down, .chip_power_down, .modulator_reset,
  .overrange_flag, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire
